// file: bench/spi_peer_model.sv
module spi_peer_model
(
  input  wire logic       i_sys_clk,
  output logic            o_xfer_active,
  output logic            o_master_mode,
  output logic            o_ss_pin_active,
  output logic            o_byte_done,
  output logic [7:0]      o_rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_xfer_active = 1'b0;
    o_master_mode = 1'b0;
    o_ss_pin_active = 1'b0;
    o_byte_done = 1'b0;
    o_rx_byte = 8'h5a;
  end

  task automatic send(input logic [7:0] b);
    @(posedge i_sys_clk);
    o_xfer_active <= 1'b1;
    o_byte_done <= 1'b1;
    o_rx_byte <= b;
    @(posedge i_sys_clk);
    o_xfer_active <= 1'b0;
    o_byte_done <= 1'b0;
    // Stale byte must not look valid
    o_rx_byte <= ~b;
  endtask : send

  task automatic level(input logic a, input logic m, input logic s);
    @(posedge i_sys_clk);
    o_xfer_active <= a;
    o_master_mode <= m;
    o_ss_pin_active <= s;
  endtask : level
endmodule : spi_peer_model

// file: bench/spi_status_flag_logic_tb_top.sv
module spi_status_flag_logic_tb_top
  import spi_flag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_STAT = {22'h0, IDX_STATUS, 2'b00};
  localparam logic [31:0] A_CTRL = {22'h0, IDX_CTRL, 2'b00};
  localparam logic [31:0] A_RX = {22'h0, IDX_RXDATA, 2'b00};
  localparam logic [31:0] A_EVT = {22'h0, IDX_EVT_STAT, 2'b00};
  localparam logic [31:0] A_MASK = {22'h0, IDX_EVT_MASK, 2'b00};
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_hsel = 1'b0;
  logic        i_hwrite = 1'b0;
  logic [1:0]  i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [31:0] o_hrdata;
  logic        o_hreadyout, o_hresp, o_xfer_halt, o_ss_release, o_spi_irq_req, o_irq;
  logic        i_xfer_active, i_master_mode, i_ss_pin_active, i_byte_done;
  logic [7:0]  i_rx_byte;
  int          miscompares, check_count, halts;
  int          m_rx, m_of, m_un, m_mm, m_busy, m_mode, m_ovw;

  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_xfer_halt === 1'b1) halts <= halts + 1;

  spi_status_flag_logic uut (.i_sys_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hrdata, .o_hresp,
    .i_xfer_active, .i_master_mode, .i_ss_pin_active, .i_byte_done, .i_rx_byte,
    .o_xfer_halt, .o_ss_release, .o_spi_irq_req, .o_irq);
  spi_peer_model peer (.i_sys_clk, .o_xfer_active(i_xfer_active),
    .o_master_mode(i_master_mode), .o_ss_pin_active(i_ss_pin_active),
    .o_byte_done(i_byte_done), .o_rx_byte(i_rx_byte));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= a;
    i_hwrite <= w;
    @(posedge i_sys_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_sys_clk);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    @(posedge i_sys_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_sys_clk);
    r = o_hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd

  function automatic logic [31:0] stat();
    return {24'h0, m_busy[0], m_mm[0], m_of[0], m_un[0], 4'h0};
  endfunction : stat

  task automatic ctrl(input int v);
    wr(A_CTRL, v);
    m_mode = v & 1;
    m_ovw = (v >> 1) & 1;
  endtask : ctrl

  task automatic byte_in(input int b);
    peer.send(b[7:0]);
    if (m_un == 0) m_rx = b;
    else if (m_mode == 1)
    begin
      m_of = 1;
      if (m_ovw == 1) m_rx = b;
    end
    m_un = 1;
  endtask : byte_in

  task automatic rx_read();
    rd(A_RX, m_rx);
    m_of = 0;
    m_un = 0;
  endtask : rx_read

  task automatic results();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  initial
  begin
    #200000;
    miscompares++;
    results();
  end

  initial
  begin
    void'($urandom(22));
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(A_STAT, 32'h0);
    rd(A_CTRL, 32'h1);
    rd(A_MASK, 32'h0);
    rd(32'h400, 32'h0);
    wr(A_MASK, 32'hf);
    for (int ov = 0; ov < 2; ov++)
    begin
      ctrl(9 + 2 * ov);
      byte_in($urandom % 256);
      rd(A_STAT, stat());
      chk(o_spi_irq_req, 32'h1);
      byte_in($urandom % 256);
      rd(A_STAT, stat());
      rx_read();
      rd(A_STAT, stat());
      chk(o_irq, 32'h1);
      wr(A_EVT, 32'hf);
      @(posedge i_sys_clk);
      chk(o_irq, 32'h0);
    end
    ctrl(8);
    halts = 0;
    byte_in($urandom % 256);
    byte_in($urandom % 256);
    rd(A_STAT, stat());
    chk(halts, 32'h1);
    rx_read();
    ctrl(32'hd);
    peer.level(1'b1, 1'b1, 1'b1);
    m_busy = 1;
    m_mm = 1;
    rd(A_STAT, stat());
    peer.level(1'b0, 1'b0, 1'b0);
    m_busy = 0;
    rd(A_STAT, stat());
    wr(A_STAT, 32'hff);
    rd(A_STAT, stat());
    wr(A_STAT, 32'h0);
    m_mm = 0;
    rd(A_STAT, stat());
    peer.level(1'b1, 1'b1, 1'b1);
    peer.level(1'b0, 1'b0, 1'b0);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    m_mode = 1;
    m_ovw = 0;
    m_of = 0;
    m_un = 0;
    m_mm = 0;
    rd(A_STAT, stat());
    rd(A_CTRL, 32'h1);
    peer.level(1'b1, 1'b1, 1'b1);
    m_busy = 1;
    rd(A_STAT, stat());
    peer.level(1'b0, 1'b0, 1'b0);
    m_busy = 0;
    byte_in($urandom % 256);
    rd(A_STAT, stat());
    chk(o_spi_irq_req, 32'h0);
    chk(o_irq, 32'h0);
    ctrl(9);
    @(posedge i_sys_clk);
    chk(o_spi_irq_req, 32'h1);
    rx_read();
    chk(o_spi_irq_req, 32'h0);
    results();
  end
endmodule : spi_status_flag_logic_tb_top

// file: bench/spi_status_flag_properties.sv
module spi_flag_checker
(
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        i_byte_done,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_xfer_halt,
  input wire logic        o_ss_release,
  input wire logic        o_spi_irq_req,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic take;
  assign take = i_hsel && i_htrans[1] && i_hready && o_hreadyout;

  a_reset_quiet: assert property ($rose(i_nrst) |-> o_hreadyout && !o_irq && !o_spi_irq_req)
    else $error("outputs busy after reset");
  a_bus_wait: assert property (take |=> !o_hreadyout ##1 o_hreadyout)
    else $error("data phase length wrong");
  a_resp_okay: assert property (!o_hresp)
    else $error("error response seen");
  a_halt_release: assert property (o_xfer_halt == o_ss_release)
    else $error("halt and release apart");
  a_halt_single: assert property (o_xfer_halt |=> !o_xfer_halt)
    else $error("halt pulse too long");
  a_halt_cause: assert property (o_xfer_halt |-> $past(i_byte_done))
    else $error("halt without byte end");
  a_read_clears: assert property ((take && !i_hwrite && i_haddr == 32'h3c4) ##1 !i_byte_done
    |=> !o_spi_irq_req)
    else $error("receive read left request");
  a_irq_hold: assert property (o_spi_irq_req && !i_hsel && o_hreadyout |=> o_spi_irq_req)
    else $error("request dropped unread");
endmodule : spi_flag_checker

bind spi_status_flag_logic spi_flag_checker u_chk (.i_sys_clk, .i_nrst, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hready, .i_byte_done, .o_hreadyout, .o_hresp, .o_xfer_halt,
  .o_ss_release, .o_spi_irq_req, .o_irq);

// file: hw/ahb_lite_reg_slave.sv
module ahb_lite_reg_slave
  import spi_flag_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_hsel,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [DATA_W-1:0]         i_hwdata,
  input  wire logic                      i_hready,
  output logic                           o_hreadyout,
  output logic [DATA_W-1:0]              o_hrdata,
  output spi_flag_pkg::reg_req_t         o_req,
  input  wire logic [DATA_W-1:0]         i_rdata
);

  ahb_state_t        state_r;
  ahb_state_t        state_nxt;
  logic              wr_r;
  logic              wr_nxt;
  logic              hit_r;
  logic              hit_nxt;
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  idx_nxt;
  logic              ready_r;
  logic              ready_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              take;

  // Address phase taken only when the bus is ready
  assign take = i_hsel && i_htrans[1] && i_hready && ready_r;

  always_comb
  begin
    state_nxt = state_r;
    wr_nxt    = wr_r;
    hit_nxt   = hit_r;
    idx_nxt   = idx_r;
    ready_nxt = ready_r;
    rdata_nxt = rdata_r;
    case (state_r)
      ST_ADDR:
      begin
        if (take)
        begin
          state_nxt = ST_DATA;
          wr_nxt    = i_hwrite;
          hit_nxt   = (i_haddr[1:0] == 2'h0) && (i_haddr[31:10] == 22'h0);
          idx_nxt   = i_haddr[9:2];
          ready_nxt = 1'b0;
        end
      end
      ST_DATA:
      begin
        state_nxt = ST_ADDR;
        ready_nxt = 1'b1;
        rdata_nxt = (!wr_r && hit_r) ? i_rdata : '0;
      end
      default:
      begin
        state_nxt = ST_ADDR;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      state_r <= ST_ADDR;
      wr_r    <= 1'b0;
      hit_r   <= 1'b0;
      idx_r   <= '0;
      ready_r <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      wr_r    <= wr_nxt;
      hit_r   <= hit_nxt;
      idx_r   <= idx_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // One-cycle strobes in the wait state of the data phase
  always_comb
  begin
    o_req.wr    = (state_r == ST_DATA) && wr_r && hit_r;
    o_req.rd    = (state_r == ST_DATA) && !wr_r && hit_r;
    o_req.idx   = idx_r;
    o_req.wdata = i_hwdata;
  end

  assign o_hreadyout = ready_r;
  assign o_hrdata    = rdata_r;

endmodule : ahb_lite_reg_slave

// file: hw/spi_flag_pkg.sv
package spi_flag_pkg;

  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 8;
  localparam int          CTRL_W        = 4;
  localparam int          EVT_W         = 4;

  // Register indexes; byte address is index times four
  localparam logic [7:0]  IDX_STATUS    = 8'hea;
  localparam logic [7:0]  IDX_CTRL      = 8'hf0;
  localparam logic [7:0]  IDX_RXDATA    = 8'hf1;
  localparam logic [7:0]  IDX_EVT_STAT  = 8'hf2;
  localparam logic [7:0]  IDX_EVT_MASK  = 8'hf3;

  // Status register fields
  localparam int          STAT_BUSY     = 7;
  localparam int          STAT_MULTIMASTER_ERROR_FLAG    = 6;
  localparam int          STAT_RXOF     = 5;
  localparam int          STAT_RXIRQ    = 4;

  // Control register fields
  localparam int          CTRL_TRANSFER_INTERRUPT_MODE   = 0;
  localparam int          CTRL_OVW      = 1;
  localparam int          CTRL_SSIN     = 2;
  localparam int          CTRL_INTEN    = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h1;

  // Event status and mask fields
  localparam int          EVT_RX        = 0;
  localparam int          EVT_OVF       = 1;
  localparam int          EVT_MULTIMASTER_ERROR_FLAG     = 2;
  localparam int          EVT_HALT      = 3;
  localparam logic [3:0]  EVT_MASK_RESET = 4'h0;

  localparam logic [7:0]  RXDATA_RESET  = 8'h00;

  typedef enum logic
  {
    ST_ADDR = 1'b0,
    ST_DATA = 1'b1
  } ahb_state_t;

  typedef struct packed
  {
    logic              wr;
    logic              rd;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic       xfer_active;
    logic       master_mode;
    logic       ss_pin_active;
    logic       byte_done;
    logic [7:0] rx_byte;
  } engine_in_t;

  function automatic logic req_hit(input reg_req_t req, input logic [IDX_W-1:0] idx);
    req_hit = req.idx == idx;
  endfunction : req_hit

endpackage : spi_flag_pkg

// file: hw/spi_status_flag_logic.sv
// Operation
// - Busy flag bit 7 follows the engine: one while moving data, zero idle.
// - Slave select driven active during master transfer sets bit 6; write zero clears.
// - In transfer interrupt mode an unread byte at next completion sets bit 5.
// - On overflow with overwrite enabled the new byte replaces the held data.
// - Reading the receive data clears bits 5 and 4.
// - New data sets bit 4; request raised while bit 4 and interrupt enable.
// - Mode zero and unread data at byte end halts transfer, releases select.
//
// Local design decision: register access over AHB-Lite.
module spi_status_flag_logic
  import spi_flag_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_hsel,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [spi_flag_pkg::DATA_W-1:0] i_hwdata,
  input  wire logic                      i_hready,
  output logic                           o_hreadyout,
  output logic [spi_flag_pkg::DATA_W-1:0] o_hrdata,
  output logic                           o_hresp,
  input  wire logic                      i_xfer_active,
  input  wire logic                      i_master_mode,
  input  wire logic                      i_ss_pin_active,
  input  wire logic                      i_byte_done,
  input  wire logic [7:0]                i_rx_byte,
  output logic                           o_xfer_halt,
  output logic                           o_ss_release,
  output logic                           o_spi_irq_req,
  output logic                           o_irq
);

  import spi_flag_pkg::*;

  engine_in_t        eng;
  reg_req_t          req;
  logic [DATA_W-1:0] rdata;

  logic              busy_r;
  logic              busy_nxt;
  logic              multimaster_error_flag_r;
  logic              multimaster_error_flag_nxt;
  logic              rxof_r;
  logic              rxof_nxt;
  logic              rxirq_r;
  logic              rxirq_nxt;
  logic [7:0]        rxdata_r;
  logic [7:0]        rxdata_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [EVT_W-1:0]  mask_r;
  logic [EVT_W-1:0]  mask_nxt;
  logic              halt_r;
  logic              halt_nxt;
  logic              ss_rel_r;
  logic              ss_rel_nxt;
  logic              req_r;
  logic              req_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              hresp_r;

  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  logic [EVT_W-1:0]  evt_stat;

  logic              transfer_interrupt_mode;
  logic              ovw_en;
  logic              ssin_en;
  logic              int_en;
  logic              rx_read;
  logic              stat_wr;
  logic              unread;
  logic              mm_event;
  logic              ovf_event;
  logic              halt_event;
  logic              store_byte;
  logic              ctrl_wr;
  logic              mask_wr;
  logic              evt_wr;
  logic              hresp_nxt;

  assign eng.xfer_active   = i_xfer_active;
  assign eng.master_mode   = i_master_mode;
  assign eng.ss_pin_active = i_ss_pin_active;
  assign eng.byte_done     = i_byte_done;
  assign eng.rx_byte       = i_rx_byte;

  ahb_lite_reg_slave u_bus
  (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hrdata    (o_hrdata),
    .o_req       (req),
    .i_rdata     (rdata)
  );

  assign transfer_interrupt_mode  = ctrl_r[CTRL_TRANSFER_INTERRUPT_MODE];
  assign ovw_en  = ctrl_r[CTRL_OVW];
  assign ssin_en = ctrl_r[CTRL_SSIN];
  assign int_en  = ctrl_r[CTRL_INTEN];

  // Register strobes, one cycle in the data phase
  assign rx_read = req.rd && req_hit(req, IDX_RXDATA);
  assign stat_wr = req.wr && req_hit(req, IDX_STATUS);
  assign ctrl_wr = req.wr && req_hit(req, IDX_CTRL);
  assign mask_wr = req.wr && req_hit(req, IDX_EVT_MASK);
  assign evt_wr  = req.wr && req_hit(req, IDX_EVT_STAT);

  // Held byte not yet read; a read in the completing cycle counts as on time
  assign unread = rxirq_r && !rx_read;

  // Only a transferring master can be upset by a foreign select
  assign mm_event   = ssin_en && eng.master_mode && eng.xfer_active && eng.ss_pin_active;
  assign ovf_event  = eng.byte_done && unread && transfer_interrupt_mode;
  assign halt_event = eng.byte_done && unread && !transfer_interrupt_mode;
  assign store_byte = eng.byte_done && !halt_event && (!unread || ovw_en);

  // Status flag group
  always_comb
  begin
    busy_nxt   = eng.xfer_active;
    multimaster_error_flag_nxt  = multimaster_error_flag_r;
    rxof_nxt   = rxof_r;
    rxirq_nxt  = rxirq_r;
    rxdata_nxt = rxdata_r;
    if (stat_wr && !req.wdata[STAT_MULTIMASTER_ERROR_FLAG])
      multimaster_error_flag_nxt = 1'b0;
    if (mm_event)
      multimaster_error_flag_nxt = 1'b1;
    if (rx_read)
    begin
      rxof_nxt  = 1'b0;
      rxirq_nxt = 1'b0;
    end
    if (ovf_event)
      rxof_nxt = 1'b1;
    if (store_byte)
    begin
      rxdata_nxt = eng.rx_byte;
      rxirq_nxt  = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      busy_r   <= 1'b0;
      multimaster_error_flag_r  <= 1'b0;
      rxof_r   <= 1'b0;
      rxirq_r  <= 1'b0;
      rxdata_r <= RXDATA_RESET;
    end
    else
    begin
      busy_r   <= busy_nxt;
      multimaster_error_flag_r  <= multimaster_error_flag_nxt;
      rxof_r   <= rxof_nxt;
      rxirq_r  <= rxirq_nxt;
      rxdata_r <= rxdata_nxt;
    end
  end

  // Control and mask group
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    if (ctrl_wr)
      ctrl_nxt = req.wdata[CTRL_W-1:0];
    if (mask_wr)
      mask_nxt = req.wdata[EVT_W-1:0];
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      ctrl_r <= CTRL_RESET;
      mask_r <= EVT_MASK_RESET;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Sticky events, write one to clear
  always_comb
  begin
    evt_set            = '0;
    evt_set[EVT_RX]    = store_byte;
    evt_set[EVT_OVF]   = ovf_event;
    evt_set[EVT_MULTIMASTER_ERROR_FLAG] = mm_event && !multimaster_error_flag_r;
    evt_set[EVT_HALT]  = halt_event;
    evt_clr            = '0;
    if (evt_wr)
      evt_clr = req.wdata[EVT_W-1:0];
  end

  sticky_flags #(
    .W (EVT_W)
  ) u_evt (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_set     (evt_set),
    .i_clr     (evt_clr),
    .o_q       (evt_stat)
  );

  // Output group, all registered
  always_comb
  begin
    halt_nxt   = halt_event;
    ss_rel_nxt = halt_event;
    // Next flag value, so a clearing read drops the request with the flag
    req_nxt    = rxirq_nxt && int_en;
    irq_nxt    = |(evt_stat & mask_r);
    hresp_nxt  = 1'b0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      halt_r   <= 1'b0;
      ss_rel_r <= 1'b0;
      req_r    <= 1'b0;
      irq_r    <= 1'b0;
      hresp_r  <= 1'b0;
    end
    else
    begin
      halt_r   <= halt_nxt;
      ss_rel_r <= ss_rel_nxt;
      req_r    <= req_nxt;
      irq_r    <= irq_nxt;
      hresp_r  <= hresp_nxt;
    end
  end

  // Status byte as software reads it
  function automatic logic [DATA_W-1:0] status_word(input logic busy,
                                                    input logic multimaster_error_flag,
                                                    input logic rxof,
                                                    input logic rxirq);
    status_word             = '0;
    status_word[STAT_BUSY]  = busy;
    status_word[STAT_MULTIMASTER_ERROR_FLAG] = multimaster_error_flag;
    status_word[STAT_RXOF]  = rxof;
    status_word[STAT_RXIRQ] = rxirq;
  endfunction : status_word

  // Read mux; unmapped indexes read zero
  always_comb
  begin
    rdata = '0;
    case (req.idx)
      IDX_STATUS:
        rdata = status_word(busy_r, multimaster_error_flag_r, rxof_r, rxirq_r);
      IDX_CTRL:
        rdata[CTRL_W-1:0] = ctrl_r;
      IDX_RXDATA:
        rdata[7:0] = rxdata_r;
      IDX_EVT_STAT:
        rdata[EVT_W-1:0] = evt_stat;
      IDX_EVT_MASK:
        rdata[EVT_W-1:0] = mask_r;
      default:
        rdata = '0;
    endcase
  end

  assign o_xfer_halt   = halt_r;
  assign o_ss_release  = ss_rel_r;
  assign o_spi_irq_req = req_r;
  assign o_irq         = irq_r;
  assign o_hresp       = hresp_r;

endmodule : spi_status_flag_logic

// file: hw/sticky_flags.sv
module sticky_flags #(
  parameter int W = 4
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    q_nxt = (q_r & ~i_clr) | i_set;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign o_q = q_r;

endmodule : sticky_flags
